// ---- dio_consts.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz pclk
// Notes:   definitions only
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

`define DIO_NLINES      6
`define DIO_NPINS       4
`define DIO_NVIRT       2
`define DIO_NUBITS      8
`define DIO_TW          16
`define DIO_AW          12

`define DIO_OFF_SEL     12'h000
`define DIO_OFF_CFG     12'h004
`define DIO_OFF_GTIME   12'h008
`define DIO_OFF_SWIDTH  12'h00c
`define DIO_OFF_LEVEL   12'h010
`define DIO_OFF_ALL     12'h014
`define DIO_OFF_PICK    12'h018
`define DIO_OFF_BITLVL  12'h01c
`define DIO_OFF_WORD    12'h020
`define DIO_OFF_MASK    12'h024

`define DIO_CFG_DIR     0
`define DIO_CFG_INV     1
`define DIO_CFG_FLT     2
`define DIO_CFG_STR     3
`define DIO_CFG_ORG     4
`define DIO_CFG_W       7

`define DIO_RST_MASK    8'hff

`define DIO_CLK_NS      10
`define DIO_GLITCH_NS   1000
`define DIO_GLITCH_CYC  ((`DIO_GLITCH_NS + `DIO_CLK_NS - 1) / `DIO_CLK_NS)
`define DIO_STRETCH_NS  10000
`define DIO_STRETCH_CYC (`DIO_STRETCH_NS / `DIO_CLK_NS)

`endif

// ---- dio_pkg.sv ----
// Purpose: types shared by the digital line stage
// Assumes: dio_consts.svh on the include path
// Notes:   widths come from the header
`include "dio_consts.svh"

package dio_pkg;

  typedef enum logic [2:0] {
    DIO_ORG_LOW   = 3'h0,
    DIO_ORG_USER  = 3'h1,
    DIO_ORG_TIMER = 3'h2,
    DIO_ORG_COUNT = 3'h3,
    DIO_ORG_QUAD  = 3'h4
  } dio_origin_e;

  typedef struct packed {
    dio_origin_e output_origin;
    logic        stretch_pulse_on;
    logic        glitch_filter_on;
    logic        polarity_invert;
    logic        pin_direction;
  } dio_cfg_s;

  typedef logic [`DIO_TW-1:0] dio_time_t;

  typedef struct packed {
    logic [2:0]                    pin_chooser;
    dio_cfg_s  [`DIO_NLINES-1:0]   cfg;
    dio_time_t [`DIO_NLINES-1:0]   glitch_filter_time;
    dio_time_t [`DIO_NLINES-1:0]   stretch_pulse_width;
    dio_time_t [`DIO_NLINES-1:0]   pcnt;
    logic [`DIO_NLINES-1:0]        prev_src;
    logic [`DIO_NLINES-1:0]        drv;
    logic [`DIO_NPINS-1:0]         oe;
    logic [`DIO_NLINES-1:0]        trig;
    logic [`DIO_NPINS-1:0]         s1;
    logic [`DIO_NPINS-1:0]         s2;
    logic [2:0]                    sw_bit_pick;
    logic [`DIO_NUBITS-1:0]        user_out;
    logic [`DIO_NUBITS-1:0]        sw_bits_write_mask;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } dio_main_s;

  typedef struct packed {
    dio_time_t cnt;
    logic      level;
  } dio_filt_s;

endpackage

// ---- dio_glitch_filter.sv ----
// Purpose: one input debounce filter
// Assumes: din already synchronised and polarity corrected
// Notes:   a level must hold len cycles before it is passed on
module dio_glitch_filter
  import dio_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         din,
  input  wire logic         en,
  input  wire dio_pkg::dio_time_t len,
  output logic              dout
);
  import dio_pkg::*;

  dio_filt_s q;
  dio_filt_s next_q;

  always_comb
  begin
    next_q = q;
    if (!en || din == q.level)
    begin
      next_q.cnt = '0;
      if (!en)
        next_q.level = din;
    end
    else if (q.cnt + 16'h0001 >= len)
    begin
      next_q.level = din;
      next_q.cnt   = '0;
    end
    else
    begin
      next_q.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= next_q;
  end

  assign dout = q.level;

  default clocking fcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  spike_reject_a: assert property (
    en && din != q.level && q.cnt + 16'h0001 < len |=> $stable(q.level))
    else $error("filter passed a level held too briefly");

  filt_accept_a: assert property (
    en && $past(en) && $changed(q.level)
    |-> $past(q.cnt) + 16'h0001 >= $past(len))
    else $error("filter accepted a level before its time");

endmodule // dio_glitch_filter

// ---- dio_line_stage.sv ----
// Purpose: digital line stage with APB register access
// Assumes: pin_in is asynchronous, event inputs share pclk
// Notes:   lines 0..3 are pins, lines 4..5 are virtual lines
//
// Summary of operation
// - software chooses which line, pin or virtual, the line registers address
// - each physical line has a direction bit: input or output
// - polarity invert flips the chosen line, for inputs and outputs alike
// - pin level reads the present state of the chosen line
// - all levels reads every line state at the moment of reading
// - output origin picks the internal signal that drives an output line
// - origins include timer done, count done and encoder step events
// - an event routed directly may last just one clock
// - glitch filter enable switches the debounce filter in or out
// - the filter discards levels shorter than the glitch filter time
// - a validated input is delayed by the glitch filter time
// - stretch enable overrides the output with a pulse on origin rise
// - the stretch pulse stays active for the programmed stretch width
// - the bit pick chooses which user output bit a bit write hits
// - a bit level write sets the picked user output bit
// - a word write updates the user output bits enabled in the write mask in one access
// - the write mask is applied to the word before storing
module dio_line_stage
  import dio_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`DIO_AW-1:0]      paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  input  wire logic [`DIO_NPINS-1:0]   pin_in,
  output logic [`DIO_NPINS-1:0]        pin_out,
  output logic [`DIO_NPINS-1:0]        pin_oe,
  input  wire logic [`DIO_NVIRT-1:0]   virt_in,
  output logic [`DIO_NVIRT-1:0]        virt_out,
  input  wire logic                    timer_done_event,
  input  wire logic                    count_done_event,
  input  wire logic                    quad_step_event,
  output logic [`DIO_NLINES-1:0]       trig_level,
  output logic [`DIO_NUBITS-1:0]       user_out
);
  import dio_pkg::*;

  localparam dio_main_s RST = '{
    glitch_filter_time:  {`DIO_NLINES{16'(`DIO_GLITCH_CYC)}},
    stretch_pulse_width: {`DIO_NLINES{16'(`DIO_STRETCH_CYC)}},
    sw_bits_write_mask:  `DIO_RST_MASK,
    default:             '0
  };

  dio_main_s q;
  dio_main_s next_q;

  logic [`DIO_NLINES-1:0] raw;
  logic [`DIO_NLINES-1:0] in_cond;
  logic [`DIO_NLINES-1:0] filt_out;
  logic [`DIO_NLINES-1:0] src;
  logic [`DIO_NLINES-1:0] lvl;
  logic                   setup;
  logic                   wr_done;

  function automatic logic dio_hit(input logic [`DIO_AW-1:0] a,
                                   input logic [`DIO_AW-1:0] off);
    return a == off;
  endfunction

  function automatic logic dio_mapped(input logic [`DIO_AW-1:0] a);
    return dio_hit(a, `DIO_OFF_SEL)    || dio_hit(a, `DIO_OFF_CFG)    ||
           dio_hit(a, `DIO_OFF_GTIME)  || dio_hit(a, `DIO_OFF_SWIDTH) ||
           dio_hit(a, `DIO_OFF_LEVEL)  || dio_hit(a, `DIO_OFF_ALL)    ||
           dio_hit(a, `DIO_OFF_PICK)   || dio_hit(a, `DIO_OFF_BITLVL) ||
           dio_hit(a, `DIO_OFF_WORD)   || dio_hit(a, `DIO_OFF_MASK);
  endfunction

  function automatic logic dio_origin(input dio_origin_e o,
                                      input logic       ubit,
                                      input logic       tmr,
                                      input logic       cnt,
                                      input logic       quad);
    logic r;
    r = 1'b0;
    case (o)
      DIO_ORG_USER:  r = ubit;
      DIO_ORG_TIMER: r = tmr;
      DIO_ORG_COUNT: r = cnt;
      DIO_ORG_QUAD:  r = quad;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction

  assign setup   = psel && !penable;
  assign wr_done = psel && penable && q.pready && pwrite;
  assign raw     = {virt_in, q.s2};

  genvar g;
  generate
    for (g = 0; g < `DIO_NLINES; g++)
    begin : g_line
      assign in_cond[g] = raw[g] ^ q.cfg[g].polarity_invert;
      assign src[g] = dio_origin(q.cfg[g].output_origin,
                                 q.user_out[g],
                                 timer_done_event,
                                 count_done_event,
                                 quad_step_event);
      assign lvl[g] = q.cfg[g].pin_direction ? q.drv[g] : in_cond[g];

      dio_glitch_filter u_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (in_cond[g]),
        .en      (q.cfg[g].glitch_filter_on),
        .len     (q.glitch_filter_time[g]),
        .dout    (filt_out[g])
      );
    end
  endgenerate

  always_comb
  begin
    next_q = q;
    next_q.s1 = pin_in;
    next_q.s2 = q.s1;
    next_q.prev_src = src;

    // line datapath
    for (int l = 0; l < `DIO_NLINES; l++)
    begin
      if (q.cfg[l].stretch_pulse_on && src[l] && !q.prev_src[l])
        next_q.pcnt[l] = q.stretch_pulse_width[l];
      else if (q.pcnt[l] != '0)
        next_q.pcnt[l] = q.pcnt[l] - 16'h0001;
      if (q.cfg[l].stretch_pulse_on)
        next_q.drv[l] = (next_q.pcnt[l] != '0)
                        ^ q.cfg[l].polarity_invert;
      else
        next_q.drv[l] = src[l] ^ q.cfg[l].polarity_invert;
      next_q.trig[l] = q.cfg[l].glitch_filter_on ? filt_out[l]
                                                 : in_cond[l];
    end
    for (int p = 0; p < `DIO_NPINS; p++)
      next_q.oe[p] = q.cfg[p].pin_direction;

    // bus answer, one access cycle
    next_q.pready  = setup;
    next_q.pslverr = 1'b0;
    next_q.prdata  = '0;
    if (setup)
    begin
      next_q.pslverr = !dio_mapped(paddr) ||
        (pwrite && dio_hit(paddr, `DIO_OFF_SEL) &&
         pwdata[31:0] >= 32'(`DIO_NLINES));
      if (!pwrite)
      begin
        if (dio_hit(paddr, `DIO_OFF_SEL))
          next_q.prdata[2:0] = q.pin_chooser;
        if (dio_hit(paddr, `DIO_OFF_CFG))
          next_q.prdata[`DIO_CFG_W-1:0] = q.cfg[q.pin_chooser];
        if (dio_hit(paddr, `DIO_OFF_GTIME))
          next_q.prdata[`DIO_TW-1:0] = q.glitch_filter_time[q.pin_chooser];
        if (dio_hit(paddr, `DIO_OFF_SWIDTH))
          next_q.prdata[`DIO_TW-1:0] = q.stretch_pulse_width[q.pin_chooser];
        if (dio_hit(paddr, `DIO_OFF_LEVEL))
          next_q.prdata[0] = lvl[q.pin_chooser];
        if (dio_hit(paddr, `DIO_OFF_ALL))
          next_q.prdata[`DIO_NLINES-1:0] = lvl;
        if (dio_hit(paddr, `DIO_OFF_PICK))
          next_q.prdata[2:0] = q.sw_bit_pick;
        if (dio_hit(paddr, `DIO_OFF_BITLVL))
          next_q.prdata[0] = q.user_out[q.sw_bit_pick];
        if (dio_hit(paddr, `DIO_OFF_WORD))
          next_q.prdata[`DIO_NUBITS-1:0] = q.user_out;
        if (dio_hit(paddr, `DIO_OFF_MASK))
          next_q.prdata[`DIO_NUBITS-1:0] = q.sw_bits_write_mask;
      end
    end

    // register writes take effect on the completing edge
    if (wr_done && !q.pslverr)
    begin
      if (dio_hit(paddr, `DIO_OFF_SEL))
        next_q.pin_chooser = pwdata[2:0];
      if (dio_hit(paddr, `DIO_OFF_CFG))
        next_q.cfg[q.pin_chooser] = dio_cfg_s'(pwdata[`DIO_CFG_W-1:0]);
      if (dio_hit(paddr, `DIO_OFF_GTIME))
        next_q.glitch_filter_time[q.pin_chooser] = pwdata[`DIO_TW-1:0];
      if (dio_hit(paddr, `DIO_OFF_SWIDTH))
        next_q.stretch_pulse_width[q.pin_chooser] = pwdata[`DIO_TW-1:0];
      if (dio_hit(paddr, `DIO_OFF_PICK))
        next_q.sw_bit_pick = pwdata[2:0];
      if (dio_hit(paddr, `DIO_OFF_BITLVL))
        next_q.user_out[q.sw_bit_pick] = pwdata[0];
      if (dio_hit(paddr, `DIO_OFF_WORD))
        next_q.user_out = (q.user_out & ~q.sw_bits_write_mask) |
                          (pwdata[`DIO_NUBITS-1:0] &
                           q.sw_bits_write_mask);
      if (dio_hit(paddr, `DIO_OFF_MASK))
        next_q.sw_bits_write_mask = pwdata[`DIO_NUBITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= RST;
    else
      q <= next_q;
  end

  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign prdata     = q.prdata;
  assign pin_out    = q.drv[`DIO_NPINS-1:0];
  assign pin_oe     = q.oe;
  assign virt_out   = q.drv[`DIO_NLINES-1:`DIO_NPINS];
  assign trig_level = q.trig;
  assign user_out   = q.user_out;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pick_bit_write_a: assert property (
    wr_done && !q.pslverr && dio_hit(paddr, `DIO_OFF_BITLVL)
    |=> user_out[$past(q.sw_bit_pick)] == $past(pwdata[0]))
    else $error("picked user bit not written");

  masked_word_a: assert property (
    wr_done && !q.pslverr && dio_hit(paddr, `DIO_OFF_WORD)
    |=> user_out == (($past(q.user_out) & ~$past(q.sw_bits_write_mask)) |
                     ($past(pwdata[7:0]) & $past(q.sw_bits_write_mask))))
    else $error("masked word write wrong");

  pin_dir_a: assert property (
    ##1 pin_oe[0] == $past(q.cfg[0].pin_direction))
    else $error("pin enable does not follow direction");

  direct_out_a: assert property (
    !q.cfg[0].stretch_pulse_on
    |=> pin_out[0] == ($past(src[0]) ^ $past(q.cfg[0].polarity_invert)))
    else $error("direct output wrong");

  stretch_load_a: assert property (
    q.cfg[0].stretch_pulse_on && src[0] && !q.prev_src[0]
    |=> q.pcnt[0] == $past(q.stretch_pulse_width[0]))
    else $error("stretch pulse not started");

  stretch_hold_a: assert property (
    q.cfg[0].stretch_pulse_on && !q.cfg[0].polarity_invert &&
    q.pcnt[0] > 16'h0001 && !(src[0] && !q.prev_src[0])
    |=> pin_out[0] ##1 pin_out[0] || q.pcnt[0] == '0)
    else $error("stretch pulse ended early");

  filter_bypass_a: assert property (
    !q.cfg[1].glitch_filter_on |=> trig_level[1] == $past(in_cond[1]))
    else $error("unfiltered input delayed");

  level_read_a: assert property (
    setup && !pwrite && dio_hit(paddr, `DIO_OFF_LEVEL)
    |=> pready && prdata[0] == $past(lvl[q.pin_chooser]))
    else $error("level read wrong");

  all_read_a: assert property (
    setup && !pwrite && dio_hit(paddr, `DIO_OFF_ALL)
    |=> prdata[5:0] == $past(lvl))
    else $error("all levels read wrong");

  unmapped_err_a: assert property (
    setup && !dio_mapped(paddr) |=> pready && pslverr)
    else $error("unmapped access not refused");

endmodule // dio_line_stage

// ---- dio_far_side.sv ----
// Purpose: far side of the line stage pins
// Assumes: trigger sources drive ext_level while the pin is an input
// Notes:   the stage wins the wire wherever its enable is high
`include "dio_consts.svh"
module dio_far_side
(
  input  wire logic [`DIO_NPINS-1:0] ext_level,
  input  wire logic [`DIO_NPINS-1:0] pin_out,
  input  wire logic [`DIO_NPINS-1:0] pin_oe,
  output logic      [`DIO_NPINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // resolved wire level fed back to the stage
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // dio_far_side

// ---- tb_digital_io_line_stage.sv ----
// Purpose: self-checking bench for the digital line stage
// Assumes: apb slave answers in its first access cycle
// Notes:   pins are resolved by dio_far_side
`include "dio_consts.svh"
module tb_digital_io_line_stage;
  timeunit 1ns;
  timeprecision 1ps;
  import dio_pkg::*;
  logic                    pclk, presetn, psel, penable, pwrite;
  logic                    pready, pslverr, rerr;
  logic [`DIO_AW-1:0]      paddr;
  logic [31:0]             pwdata, prdata, rdat;
  logic [`DIO_NPINS-1:0]   pin_in, pin_out, pin_oe, ext_level;
  logic [`DIO_NVIRT-1:0]   virt_in, virt_out;
  logic [2:0]              evt;
  logic [`DIO_NLINES-1:0]  trig_level;
  logic [`DIO_NUBITS-1:0]  user_out;
  int                      err_total, total_checks, pw;

  dio_line_stage dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .virt_in(virt_in),
    .virt_out(virt_out), .timer_done_event(evt[0]),
    .count_done_event(evt[1]), .quad_step_event(evt[2]),
    .trig_level(trig_level), .user_out(user_out));
  dio_far_side far (.ext_level(ext_level), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task close_out;
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [`DIO_AW-1:0] a,
           input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    #1;
    // look at the settled answer that the next edge will sample
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      err_total++;
      close_out();
    end
    rdat = prdata;
    rerr = pslverr;
    // completing edge: write lands here, then release
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one-cycle event on origin k, then count cycles pin 0 sits at lvl
  task fire(input int k, input logic lvl);
    pw = 0;
    @(posedge pclk);
    evt <= 3'(1 << k);
    @(posedge pclk);
    evt <= 3'h0;
    repeat (20)
    begin
      #1;
      if (pin_out[0] === lvl) pw++;
      @(posedge pclk);
    end
  endtask

  task t_reset_vals;
    apb(1'b0, `DIO_OFF_CFG, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, `DIO_OFF_GTIME, 32'h0);
    chk(rdat, 32'h64);
    apb(1'b0, `DIO_OFF_SWIDTH, 32'h0);
    chk(rdat, 32'h3e8);
    apb(1'b0, `DIO_OFF_MASK, 32'h0);
    chk(rdat, 32'hff);
    apb(1'b0, `DIO_OFF_WORD, 32'h0);
    chk(rdat, 32'h0);
  endtask

  task t_errors;
    apb(1'b0, 12'h0fc, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    apb(1'b1, `DIO_OFF_SEL, 32'h6);
    chk(rerr, 1'b1);
    apb(1'b0, `DIO_OFF_SEL, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, `DIO_OFF_ALL, 32'h3f);
    chk(rerr, 1'b0);
  endtask

  task t_user_bits;
    apb(1'b1, `DIO_OFF_PICK, 32'h3);
    apb(1'b1, `DIO_OFF_BITLVL, 32'h1);
    chk(user_out, 8'h08);
    apb(1'b0, `DIO_OFF_BITLVL, 32'h0);
    chk(rdat, 32'h1);
    apb(1'b1, `DIO_OFF_MASK, 32'hf0);
    apb(1'b1, `DIO_OFF_WORD, 32'hb5);
    chk(user_out, 8'hb8);
    apb(1'b0, `DIO_OFF_WORD, 32'h0);
    chk(rdat, 32'hb8);
    apb(1'b1, `DIO_OFF_SEL, 32'h4);
    apb(1'b1, `DIO_OFF_CFG, 32'h11);
    cyc(2);
    chk(virt_out, 2'b01);
    apb(1'b0, `DIO_OFF_LEVEL, 32'h0);
    chk(rdat, 32'h1);
  endtask

  task t_outputs;
    apb(1'b1, `DIO_OFF_SEL, 32'h0);
    apb(1'b1, `DIO_OFF_SWIDTH, 32'h5);
    apb(1'b1, `DIO_OFF_CFG, 32'h29);
    cyc(2);
    chk(pin_oe, 4'h1);
    fire(0, 1'b1);
    chk(pw, 32'h5);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, `DIO_OFF_CFG, 32'h03 | ((k + 2) << 4));
      fire(k, 1'b0);
      chk(pw, 32'h1);
    end
    apb(1'b0, `DIO_OFF_LEVEL, 32'h0);
    chk(rdat, 32'h1);
    // virtual input line 5 high, read back with the pins
    virt_in <= 2'b10;
    apb(1'b0, `DIO_OFF_ALL, 32'h0);
    chk(rdat, 32'h31);
  endtask

  task t_inputs;
    apb(1'b1, `DIO_OFF_SEL, 32'h1);
    apb(1'b1, `DIO_OFF_CFG, 32'h2);
    cyc(4);
    chk(trig_level[1], 1'b1);
    @(posedge pclk);
    ext_level[1] <= 1'b1;
    cyc(2);
    chk(trig_level[1], 1'b1);
    cyc(1);
    chk(trig_level[1], 1'b0);
    // falling pin edge must show as an active rise
    @(posedge pclk);
    ext_level[1] <= 1'b0;
    cyc(3);
    chk(trig_level[1], 1'b1);
    apb(1'b1, `DIO_OFF_SEL, 32'h2);
    apb(1'b1, `DIO_OFF_GTIME, 32'h8);
    apb(1'b1, `DIO_OFF_CFG, 32'h4);
    @(posedge pclk);
    ext_level[2] <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_level[2] <= 1'b0;
    pw = 0;
    repeat (20)
    begin
      cyc(1);
      if (trig_level[2] !== 1'b0) pw++;
    end
    chk(pw, 32'h0);
    @(posedge pclk);
    ext_level[2] <= 1'b1;
    // two sync flops, eight filter cycles, one output flop
    cyc(10);
    chk(trig_level[2], 1'b0);
    cyc(1);
    chk(trig_level[2], 1'b1);
  endtask

  initial
  begin
    err_total = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext_level = '0;
    virt_in = '0;
    evt = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_errors();
    t_user_bits();
    t_outputs();
    t_inputs();
    close_out();
  end
endmodule // tb_digital_io_line_stage
